// >>> design/spi_command_adapter.v
// Overview of operation
// - spi commands open with the spi keyword
// - second token picks channel one or two
// - third token picks one of four modes
// - low and high tokens drive chip select
// - read token reads byte, hex token writes
// - idle low, sample rising, first edge
// - idle low, sample falling, second edge
// - idle high, sample falling, first edge
// - idle high, sample rising, second edge
// - general commands open with general keyword
// - control word sets eight pins, msb pin eight
`include "spi_cmd_map.vh"
`default_nettype none

module cmd_fifo #(
  parameter WIDTH = `FIFO_WIDTH,
  parameter DEPTH = `FIFO_DEPTH,
  parameter AW    = `FIFO_AW
) (
  input  wire             ref_clk,
  input  wire             rst,
  input  wire             ce,
  input  wire             in_valid,
  input  wire [WIDTH-1:0] in_data,
  output reg              in_ready,
  output reg              out_valid,
  output wire [WIDTH-1:0] out_data,
  input  wire             out_ready
);
  localparam [AW:0]   FULL = DEPTH;
  localparam [AW:0]   NONE = 0;
  localparam [AW:0]   ONE  = 1;
  localparam [AW-1:0] STEP = 1;
  reg  [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg  [AW-1:0]    wr_q;
  reg  [AW-1:0]    rd_q;
  reg  [AW:0]      cnt_q;
  reg  [AW:0]      cnt_d;
  wire             push = in_valid & in_ready;
  wire             pop  = out_valid & out_ready;

  assign out_data = mem_q[rd_q];

  always @* begin
    cnt_d = cnt_q;
    if (push & ~pop)
      cnt_d = cnt_q + ONE;
    else if (pop & ~push)
      cnt_d = cnt_q - ONE;
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      wr_q      <= {AW{1'b0}};
      rd_q      <= {AW{1'b0}};
      cnt_q     <= NONE;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else if (ce) begin
      if (push) begin
        mem_q[wr_q] <= in_data;
        wr_q        <= wr_q + STEP;
      end
      if (pop)
        rd_q <= rd_q + STEP;
      cnt_q     <= cnt_d;
      // flags registered from the next count, so both stay honest
      in_ready  <= (cnt_d != FULL);
      out_valid <= (cnt_d != NONE);
    end
  end
endmodule // cmd_fifo

module spi_command_adapter #(
  parameter FIFO_DEPTH = `FIFO_DEPTH,
  parameter FIFO_AW    = `FIFO_AW
) (
  input  wire       ref_clk,
  input  wire       rst,
  input  wire       ce,
  input  wire       cmd_valid,
  input  wire [7:0] cmd_data,
  output wire       cmd_ready,
  input  wire       link_clk,
  input  wire [1:0] miso,
  output reg  [1:0] sclk,
  output reg  [1:0] mosi,
  output reg  [1:0] cs_n,
  output reg  [7:0] ctrl_pins,
  output reg  [7:0] rd_data,
  output reg        rd_valid,
  output reg        busy,
  output reg        cmd_err
);
  localparam [6:0] ST_FIRST  = 7'h01;
  localparam [6:0] ST_CHAN   = 7'h02;
  localparam [6:0] ST_MODE   = 7'h04;
  localparam [6:0] ST_XFER   = 7'h08;
  localparam [6:0] ST_GENOP  = 7'h10;
  localparam [6:0] ST_GENVAL = 7'h20;
  localparam [6:0] ST_SKIP   = 7'h40;

  function [4:0] hex_val;
    input [7:0] c;
    reg   [7:0] up_t;
    reg   [7:0] lo_t;
    begin
      // letters worked out in eight bits, then cut to a nibble on purpose
      up_t = c - `ASC_UPA + `HEX_ALPHA_OFS;
      lo_t = c - `ASC_LOA + `HEX_ALPHA_OFS;
      if (c >= `ASC_DIG_LO && c <= `ASC_DIG_HI)
        hex_val = {1'b1, c[3:0]};
      else if (c >= `ASC_UPA && c <= `ASC_UPF)
        hex_val = {1'b1, up_t[3:0]};
      else if (c >= `ASC_LOA && c <= `ASC_LOF)
        hex_val = {1'b1, lo_t[3:0]};
      else
        hex_val = 5'h00;
    end
  endfunction

  wire       fifo_valid;
  wire [7:0] ch;
  wire       take = fifo_valid & ~busy;

  cmd_fifo #(.WIDTH(`FIFO_WIDTH), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (cmd_valid),
    .in_data   (cmd_data),
    .in_ready  (cmd_ready),
    .out_valid (fifo_valid),
    .out_data  (ch),
    .out_ready (~busy)
  );

  // link clock and miso cross into ref_clk through two flops
  reg        lk_s1_q, lk_s2_q, lk_s3_q;
  reg  [1:0] miso_s1_q, miso_s2_q;
  wire       tick = lk_s2_q ^ lk_s3_q;

  reg  [6:0]  st_q, st_d;
  reg  [31:0] tok_q;
  reg  [2:0]  len_q;
  reg  [7:0]  dec_q;
  reg         dec_ok_q;
  reg         chan_q;
  reg  [1:0]  cpol_q, cpha_q;
  reg  [7:0]  tx_q, rx_q;
  reg  [3:0]  half_q;
  reg         rd_op_q;
  reg         a_cs_lo, a_cs_hi, a_rd, a_wr, a_mode, a_ctrl, a_err, a_chan, chan_pick;
  reg  [1:0]  mode_pick;

  wire        is_eol = (ch == `ASC_LF) || (ch == `ASC_CR);
  wire        is_sep = (ch == `ASC_SPACE) || is_eol;
  wire        eval   = take & is_sep & (len_q != 3'h0);
  wire [4:0]  hx_hi  = hex_val(tok_q[15:8]);
  wire [4:0]  hx_lo  = hex_val(tok_q[7:0]);
  wire        is_hex = (len_q == `LEN_TWO) & hx_hi[4] & hx_lo[4];
  wire        is_dec = dec_ok_q & (len_q <= `LEN_THREE);
  wire [4:0]  dg     = hex_val(ch);
  wire [11:0] dec_nx = {4'h0, dec_q} * `DEC_TEN + {8'h00, dg[3:0]};
  wire        cpol_c = cpol_q[chan_q];
  wire        cpha_c = cpha_q[chan_q];
  wire        lead   = ~half_q[0];
  wire        samp   = lead ^ cpha_c;
  wire [7:0]  rx_nx  = samp ? {rx_q[6:0], miso_s2_q[chan_q]} : rx_q;
  wire [7:0]  wr_byte = {hx_hi[3:0], hx_lo[3:0]};
  wire [7:0]  ld_byte = a_rd ? `READ_FILL : wr_byte;

  always @* begin
    st_d = st_q;
    {a_cs_lo, a_cs_hi, a_rd, a_wr, a_mode, a_ctrl, a_err, a_chan} = 8'h00;
    chan_pick = chan_q;
    mode_pick = `MODE_IL_FIRST;
    if (eval) begin
      case (st_q)
        ST_FIRST: begin
          if (tok_q == `TOK_SPI && len_q == `LEN_THREE)
            st_d = ST_CHAN;
          else if (tok_q == `TOK_GENERAL && len_q == `LEN_THREE)
            st_d = ST_GENOP;
          else begin
            a_err = 1'b1;
            st_d  = ST_SKIP;
          end
        end
        ST_CHAN: begin
          a_chan = 1'b1;
          st_d   = ST_MODE;
          if (tok_q == `TOK_CHAN_ONE && len_q == `LEN_THREE)
            chan_pick = 1'b0;
          else if (tok_q == `TOK_CHAN_TWO && len_q == `LEN_THREE)
            chan_pick = 1'b1;
          else begin
            a_chan = 1'b0;
            a_err  = 1'b1;
            st_d   = ST_SKIP;
          end
        end
        ST_MODE: begin
          a_mode = len_q == `LEN_FOUR;
          if (tok_q == `TOK_IL_FIRST)
            mode_pick = `MODE_IL_FIRST;
          else if (tok_q == `TOK_IL_SECOND)
            mode_pick = `MODE_IL_SECOND;
          else if (tok_q == `TOK_IH_FIRST)
            mode_pick = `MODE_IH_FIRST;
          else if (tok_q == `TOK_IH_SECOND)
            mode_pick = `MODE_IH_SECOND;
          else
            a_mode = 1'b0;
          a_err = ~a_mode;
          st_d  = a_mode ? ST_XFER : ST_SKIP;
        end
        ST_XFER: begin
          if (tok_q == `TOK_CS_LOW && len_q == `LEN_ONE)
            a_cs_lo = 1'b1;
          else if (tok_q == `TOK_CS_HIGH && len_q == `LEN_ONE)
            a_cs_hi = 1'b1;
          else if (tok_q == `TOK_READ && len_q == `LEN_ONE)
            a_rd = 1'b1;
          else if (is_hex)
            a_wr = 1'b1;
          else begin
            a_err = 1'b1;
            st_d  = ST_SKIP;
          end
        end
        ST_GENOP: begin
          if (tok_q == `TOK_CONTROL && len_q == `LEN_FOUR)
            st_d = ST_GENVAL;
          else begin
            a_err = 1'b1;
            st_d  = ST_SKIP;
          end
        end
        ST_GENVAL: begin
          a_ctrl = is_dec;
          a_err  = ~is_dec;
          st_d   = ST_SKIP;
        end
        ST_SKIP: st_d = ST_SKIP;
        default: st_d = ST_FIRST;
      endcase
    end
    if (take & is_eol) begin
      if (st_d == ST_CHAN || st_d == ST_MODE || st_d == ST_GENOP || st_d == ST_GENVAL)
        a_err = 1'b1;
      st_d = ST_FIRST;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      lk_s1_q   <= 1'b0;
      lk_s2_q   <= 1'b0;
      lk_s3_q   <= 1'b0;
      miso_s1_q <= 2'h0;
      miso_s2_q <= 2'h0;
      st_q      <= ST_FIRST;
      tok_q     <= 32'h00000000;
      len_q     <= 3'h0;
      dec_q     <= 8'h00;
      dec_ok_q  <= 1'b1;
      chan_q    <= 1'b0;
      cpol_q    <= 2'h0;
      cpha_q    <= 2'h0;
      sclk      <= 2'h0;
      mosi      <= 2'h0;
      cs_n      <= 2'h3;
      ctrl_pins <= `CTRL_RESET;
      tx_q      <= 8'h00;
      rx_q      <= `RX_RESET;
      half_q    <= `HALF_FIRST;
      rd_op_q   <= 1'b0;
      rd_data   <= `RX_RESET;
      rd_valid  <= 1'b0;
      busy      <= 1'b0;
      cmd_err   <= 1'b0;
    end else if (ce) begin
      lk_s1_q   <= link_clk;
      lk_s2_q   <= lk_s1_q;
      lk_s3_q   <= lk_s2_q;
      miso_s1_q <= miso;
      miso_s2_q <= miso_s1_q;
      st_q      <= st_d;
      cmd_err   <= a_err;
      rd_valid  <= 1'b0;
      if (take) begin
        if (is_sep) begin
          tok_q    <= 32'h00000000;
          len_q    <= 3'h0;
          dec_q    <= 8'h00;
          dec_ok_q <= 1'b1;
        end else begin
          tok_q <= {tok_q[23:0], ch};
          if (len_q != `LEN_MAX)
            len_q <= len_q + `LEN_ONE;
          // digits only; any other character or over 255 spoils the value
          if (ch >= `ASC_DIG_LO && ch <= `ASC_DIG_HI && dec_nx <= `DEC_MAX)
            dec_q <= dec_nx[7:0];
          else
            dec_ok_q <= 1'b0;
        end
      end
      if (a_chan)
        chan_q <= chan_pick;
      if (a_mode) begin
        cpol_q[chan_q] <= mode_pick[1];
        cpha_q[chan_q] <= mode_pick[0];
        sclk[chan_q]   <= mode_pick[1];
      end
      // only a chip select token moves cs; bytes leave it alone
      if (a_cs_lo)
        cs_n[chan_q] <= 1'b0;
      if (a_cs_hi)
        cs_n[chan_q] <= 1'b1;
      if (a_ctrl)
        ctrl_pins <= dec_q;
      if (a_rd | a_wr) begin
        busy    <= 1'b1;
        half_q  <= `HALF_FIRST;
        rd_op_q <= a_rd;
        if (cpha_c) begin
          tx_q <= ld_byte;
        end else begin
          mosi[chan_q] <= ld_byte[7];
          tx_q         <= {ld_byte[6:0], 1'b0};
        end
      end else if (busy & tick) begin
        // one link clock edge per sclk half period
        sclk[chan_q] <= ~sclk[chan_q];
        half_q       <= half_q + 4'h1;
        rx_q         <= rx_nx;
        if (~samp && half_q != `HALF_LAST) begin
          mosi[chan_q] <= tx_q[7];
          tx_q         <= {tx_q[6:0], 1'b0};
        end
        if (half_q == `HALF_LAST) begin
          busy <= 1'b0;
          if (rd_op_q) begin
            rd_data  <= rx_nx;
            rd_valid <= 1'b1;
          end
        end
      end
    end
  end
endmodule // spi_command_adapter

`default_nettype wire

// >>> design/spi_cmd_map.vh
`ifndef SPI_CMD_MAP_VH
`define SPI_CMD_MAP_VH

// token codes, right aligned ascii, unused upper bytes zero
`define TOK_SPI        32'h00535049
`define TOK_CHAN_ONE   32'h00434831
`define TOK_CHAN_TWO   32'h00434832
`define TOK_IL_FIRST   32'h42524548
`define TOK_IL_SECOND  32'h4252454c
`define TOK_IH_FIRST   32'h41464548
`define TOK_IH_SECOND  32'h4146454c
`define TOK_CS_LOW     32'h0000004c
`define TOK_CS_HIGH    32'h00000048
`define TOK_READ       32'h00000052
`define TOK_GENERAL    32'h00434d44
`define TOK_CONTROL    32'h4354524c

// token lengths
`define LEN_ONE        3'h1
`define LEN_TWO        3'h2
`define LEN_THREE      3'h3
`define LEN_FOUR       3'h4
`define LEN_MAX        3'h7

// separators and digit ranges
`define ASC_SPACE      8'h20
`define ASC_LF         8'h0a
`define ASC_CR         8'h0d
`define ASC_DIG_LO     8'h30
`define ASC_DIG_HI     8'h39
`define ASC_UPA        8'h41
`define ASC_UPF        8'h46
`define ASC_LOA        8'h61
`define ASC_LOF        8'h66
`define HEX_ALPHA_OFS  8'h0a

// decimal accumulation
`define DEC_TEN        12'h00a
`define DEC_MAX        12'h0ff

// mode codes {cpol, cpha}
`define MODE_IL_FIRST  2'h0
`define MODE_IL_SECOND 2'h1
`define MODE_IH_FIRST  2'h2
`define MODE_IH_SECOND 2'h3

// byte transfer
`define HALF_FIRST     4'h0
`define HALF_LAST      4'hf
`define READ_FILL      8'h00
`define CTRL_RESET     8'h00
`define RX_RESET       8'h00

// command buffer
`define FIFO_WIDTH     8
`define FIFO_DEPTH     16
`define FIFO_AW        4

`endif

// >>> dv/spi_command_adapter_sva.sv
`default_nettype none
module spi_command_adapter_sva (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       ce,
  input wire logic [1:0] mosi,
  input wire logic [1:0] cs_n,
  input wire logic [7:0] ctrl_pins,
  input wire logic [7:0] rd_data,
  input wire logic       rd_valid,
  input wire logic       busy,
  input wire logic       cmd_err
);
  logic rst_q;
  // past values straddling a reset are stale
  always @(posedge ref_clk) rst_q <= rst;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst || rst_q);
  sequence s_hold; busy [*8] ##1 busy [*8]; endsequence
  sequence s_end; ##[100:150] $fell(busy); endsequence
  a_reset_vals: assert property (disable iff (1'b0) rst && ce |=> cs_n == 2'h3 && ctrl_pins == 8'h00)
    else $error("outputs not at reset level");
  a_xfer_long: assert property ($rose(busy) |=> s_hold)
    else $error("byte transfer too short");
  a_xfer_ends: assert property ($rose(busy) |-> s_end)
    else $error("byte transfer length wrong");
  a_cs_steady: assert property (busy |-> $stable(cs_n))
    else $error("chip select moved in a transfer");
  a_ctrl_steady: assert property (busy |-> $stable(ctrl_pins))
    else $error("control pins moved");
  a_rd_after: assert property (rd_valid |-> !busy && $past(busy))
    else $error("read pulse not at transfer end");
  a_rd_hold: assert property (!rd_valid |-> $stable(rd_data))
    else $error("read data changed without pulse");
  a_mosi_quiet: assert property (!busy && !$past(busy) |-> $stable(mosi))
    else $error("serial out moved while idle");
  a_err_pulse: assert property (cmd_err |=> !cmd_err)
    else $error("error flag longer than a cycle");
endmodule // spi_command_adapter_sva
bind spi_command_adapter spi_command_adapter_sva spi_command_adapter_sva_inst (.ref_clk(ref_clk), .rst(rst),
  .ce(ce), .mosi(mosi), .cs_n(cs_n), .ctrl_pins(ctrl_pins), .rd_data(rd_data), .rd_valid(rd_valid),
  .busy(busy), .cmd_err(cmd_err));
`default_nettype wire

// >>> dv/spi_periph_model.sv
`default_nettype none
module spi_periph_model (
  input  wire logic       sclk,
  input  wire logic       mosi,
  input  wire logic       cs_n,
  input  wire logic [1:0] mode,
  input  wire logic [7:0] tx,
  output var  logic       miso,
  output var  logic [7:0] rx
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] sh, acc;
  int n;
  initial miso = 1'b0;
  initial rx = 8'h00;
  // released line toggles so a stale bit cannot pass
  always @(posedge cs_n) miso <= ~miso;
  always @(negedge cs_n) begin
    n = 0;
    sh = mode[0] ? tx : tx << 1;
    if (!mode[0]) miso <= tx[7];
  end
  always @(sclk) begin
    if (cs_n === 1'b0) begin
      if (sclk ^ mode[1] ^ mode[0]) begin
        acc = {acc[6:0], mosi};
        n = n + 1;
        if (n == 8) begin
          rx <= acc;
          n = 0;
          sh = tx;
        end
      end else begin
        miso <= sh[7];
        sh = sh << 1;
      end
    end
  end
endmodule // spi_periph_model
`default_nettype wire

// >>> dv/tb_spi_command_adapter.sv
`include "spi_cmd_map.vh"
`default_nettype none
module tb_spi_command_adapter;
  timeunit 1ns;
  timeprecision 100ps;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        cmd_valid = 1'b0;
  logic        ce = 1'b1;
  logic [7:0]  cmd_data = 8'h00;
  logic        link_clk = 1'b0;
  wire  [1:0]  miso;
  logic [1:0]  sclk, mosi, cs_n;
  logic [1:0]  md [2] = '{2'h0, 2'h0};
  logic [7:0]  tx [2] = '{8'h00, 8'h00};
  wire  [7:0]  rx [2];
  logic [7:0]  ctrl_pins, rd_data;
  logic        cmd_ready, rd_valid, busy, cmd_err;
  logic        full_seen = 1'b0;
  int          n_errors = 0, compares = 0, n_rd = 0, n_err = 0;
  int          cv [4] = '{0, 3, 128, 255};
  logic [31:0] mtok [4] = '{`TOK_IL_FIRST, `TOK_IL_SECOND, `TOK_IH_FIRST, `TOK_IH_SECOND};
  logic [31:0] ctok [2] = '{`TOK_CHAN_ONE, `TOK_CHAN_TWO};
  always #4 ref_clk = ~ref_clk;
  always #62.5 link_clk = ~link_clk;
  always @(posedge ref_clk) begin
    if (rd_valid === 1'b1) n_rd++;
    if (cmd_err === 1'b1) n_err++;
    if (cmd_ready === 1'b0) full_seen <= 1'b1;
  end
  spi_command_adapter spi_command_adapter_inst (.ref_clk(ref_clk), .rst(rst), .ce(ce), .cmd_valid(cmd_valid),
    .cmd_data(cmd_data), .cmd_ready(cmd_ready), .link_clk(link_clk), .miso(miso), .sclk(sclk), .mosi(mosi),
    .cs_n(cs_n), .ctrl_pins(ctrl_pins), .rd_data(rd_data), .rd_valid(rd_valid), .busy(busy), .cmd_err(cmd_err));
  spi_periph_model periph_one (.sclk(sclk[0]), .mosi(mosi[0]), .cs_n(cs_n[0]), .mode(md[0]), .tx(tx[0]),
    .miso(miso[0]), .rx(rx[0]));
  spi_periph_model periph_two (.sclk(sclk[1]), .mosi(mosi[1]), .cs_n(cs_n[1]), .mode(md[1]), .tx(tx[1]),
    .miso(miso[1]), .rx(rx[1]));
  task automatic stop_test();
    if (n_errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // valid stays up between characters, dropped only at line end
  task automatic put(input logic [7:0] c);
    cmd_valid <= 1'b1;
    cmd_data <= c;
    @(posedge ref_clk);
    while (cmd_ready !== 1'b1) @(posedge ref_clk);
  endtask
  task automatic tok(input logic [31:0] t);
    for (int i = 3; i >= 0; i--) if (t[i*8+:8] != 8'h00) put(t[i*8+:8]);
    put(`ASC_SPACE);
  endtask
  // either letter case, so both decoder paths get exercised
  function automatic logic [7:0] hx(input logic [3:0] v, input logic up);
    if (v < 4'ha) return `ASC_DIG_LO + 8'(v);
    return (up ? `ASC_UPA : `ASC_LOA) + 8'(v) - `HEX_ALPHA_OFS;
  endfunction
  task automatic eol();
    int k;
    put(($urandom & 1) ? `ASC_CR : `ASC_LF);
    cmd_valid <= 1'b0;
    k = 0;
    for (int j = 0; j < 3000 && k < 10; j++) begin
      @(posedge ref_clk);
      k = (busy === 1'b0) ? k + 1 : 0;
    end
  endtask
  task automatic ctrl(input int v);
    tok(`TOK_GENERAL);
    tok(`TOK_CONTROL);
    if (v > 99) put(`ASC_DIG_LO + 8'(v / 100));
    if (v > 9) put(`ASC_DIG_LO + 8'(v / 10 % 10));
    put(`ASC_DIG_LO + 8'(v % 10));
    eol();
  endtask
  initial begin
    logic [7:0] b, pins;
    int m, c, e;
    void'($urandom(32'h2e3481f9));
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    chk("cs_n", 8'h03, {6'h00, cs_n});
    for (int i = 0; i < 8; i++) begin
      pins = (i < 4) ? 8'(cv[i]) : 8'($urandom);
      ctrl(int'(pins));
      repeat (20) @(posedge ref_clk);
      chk("ctrl_pins", pins, ctrl_pins);
    end
    // clock enable low: a line offered while frozen must never land
    ce <= 1'b0;
    ctrl(int'(~pins));
    ce <= 1'b1;
    repeat (20) @(posedge ref_clk);
    chk("ctrl_pins frozen", pins, ctrl_pins);
    e = n_err;
    ctrl(300);
    chk("ctrl_pins", pins, ctrl_pins);
    tok(`TOK_CHAN_ONE);
    eol();
    chk("errors", 8'(e + 2), 8'(n_err));
    for (int i = 0; i < 8; i++) begin
      m = i % 4;
      c = i / 4;
      md[c] = 2'(m);
      tx[c] = 8'($urandom);
      b = 8'($urandom);
      e = n_rd;
      // six writes queue behind the read and fill the buffer
      tok(`TOK_SPI);
      tok(ctok[c]);
      tok(mtok[m]);
      tok(`TOK_CS_LOW);
      tok(`TOK_READ);
      repeat (6) begin
        put(hx(b[7:4], b[0]));
        put(hx(b[3:0], b[1]));
        put(`ASC_SPACE);
      end
      eol();
      chk("rd_data", tx[c], rd_data);
      chk("periph rx", b, rx[c]);
      chk("reads", 8'(e + 1), 8'(n_rd));
      chk("cs_n", (c == 1) ? 8'h01 : 8'h02, {6'h00, cs_n});
      chk("sclk idle", {7'h00, md[c][1]}, {7'h00, sclk[c]});
      tok(`TOK_SPI);
      tok(ctok[c]);
      tok(mtok[m]);
      tok(`TOK_CS_HIGH);
      eol();
      chk("cs_n", 8'h03, {6'h00, cs_n});
      chk("ctrl_pins", pins, ctrl_pins);
    end
    chk("buffer full", 8'h01, {7'h00, full_seen});
    stop_test();
  end
  initial begin
    repeat (40000) @(posedge ref_clk);
    n_errors++;
    stop_test();
  end
endmodule // tb_spi_command_adapter
`default_nettype wire
